// *** src/hmews_count.sv ***
// Loadable down counter shared by the sequencer phases.
// Assumes the owner loads it on entry to every phase but HALTED and RUN; it stops at zero.
`timescale 1ns/100ps
`default_nettype none
module hmews_count (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          load,
    input  wire logic [hmews_pkg::CNT_W-1:0]   load_val,
    output logic                               zero
);
    import hmews_pkg::*;

    logic [CNT_W-1:0] cnt_q;

    // Load wins over counting; decrement until zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign zero = (cnt_q == '0);

endmodule : hmews_count
`default_nettype wire

// *** src/hmews_pkg.sv ***
// Package for the halt-mode entry and wake sequencer.
// Assumes one core clock at 25 MHz; all counts are in cycles of that clock.
package hmews_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and counter geometry
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          CNT_W         = 18;

    // Hold-off lengths after the sleep instruction, per divider select
    localparam int          HOLD_CYC_LOW  = 16;
    localparam int          HOLD_CYC_MID  = 32;
    localparam int          HOLD_CYC_HIGH = 64;

    // External clock output stop point, inside the 32..45 cycle window
    localparam logic [6:0]  EXTCLK_STOP_CYC = 7'h20;
    // Least spacing between sleep and an accepted wake edge
    localparam logic [6:0]  WAKE_GUARD_CYC  = 7'h04;
    localparam logic [6:0]  ENT_CNT_MAX     = 7'h7f;

    // Oscillator start-up time, plain default
    localparam int          OSC_SETTLE_NS  = 40000;
    localparam int          OSC_SETTLE_CYC = OSC_SETTLE_NS / CLK_PERIOD_NS;

    // PLL lock interval, applied even with the PLL bypassed
    localparam int          LOCK_CYC_DEF = 131072;

    // Latency from lock to resumed execution
    localparam int          RESUME_FLASH_CYC = 1125;
    localparam int          RESUME_RAM_CYC   = 35;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer phases, also shown on the status output
    typedef enum logic [2:0] {
        HMEWS_RUN    = 3'b000,
        HMEWS_HOLD   = 3'b001,
        HMEWS_HALTED = 3'b010,
        HMEWS_SETTLE = 3'b011,
        HMEWS_LOCK   = 3'b100,
        HMEWS_RESUME = 3'b101
    } hmews_phase_t;

    // Clock and power controls that travel together
    typedef struct packed {
        logic sys_clk_en;
        logic core_clk_en;
        logic periph_clk_en;
        logic pll_power_en;
        logic osc_en;
        logic ext_clk_out_en;
    } hmews_gate_t;

    localparam hmews_gate_t GATE_RESET = 6'h3f;

endpackage : hmews_pkg

// *** src/hmews_sync.sv ***
// Two-stage synchroniser for the wake pin.
// Assumes the pin is asynchronous to core_clk; only the second stage leaves.
`timescale 1ns/100ps
`default_nettype none
module hmews_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      sync_out
);
    import hmews_pkg::*;

    logic meta_q;

    // Pin idles high, so both stages reset high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : hmews_sync
`default_nettype wire

// *** src/hmews_top.sv ***
// Halt-mode entry and wake sequencer: entry hold-off, clock and power
// gating, wake on a falling pin edge, oscillator settle, PLL lock wait,
// and resume latency.
// Assumes sleep_exec is a one-cycle pulse from core logic on core_clk and
// that the wake pin is asynchronous.
//
// Behaviour
// - Sleep with halt selected starts entry
// - Hold system clock 16/32/64 cycles by divider
// - Hold-off never extended for external memory
// - After hold-off gate peripherals, power PLL down
// - Crystal source also stops the oscillator
// - Wake pin falling edge restarts oscillator
// - Wait 131072 cycles for PLL lock
// - Lock wait applies even with PLL bypassed
// - After lock enable clocks, leave, service interrupt
// - Resume within 1125 flash or 35 RAM
// - External clock out low 32..45 cycles
`timescale 1ns/100ps
`default_nettype none
module hmews_top #(
    parameter int LOCK_CYCLES = hmews_pkg::LOCK_CYC_DEF
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  sleep_exec,
    input  wire logic                  halt_selected,
    input  wire logic [1:0]            clock_divider_select,
    input  wire logic                  crystal_source,
    input  wire logic                  wake_from_flash,
    input  wire logic                  wake_pin,
    output hmews_pkg::hmews_gate_t     clk_gate,
    output hmews_pkg::hmews_phase_t    phase,
    output logic                       exec_resume,
    output logic                       irq_service
);
    import hmews_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Derived counts
    localparam logic [CNT_W-1:0] LD_HOLD_LOW  = CNT_W'(HOLD_CYC_LOW - 1);
    localparam logic [CNT_W-1:0] LD_HOLD_MID  = CNT_W'(HOLD_CYC_MID - 1);
    localparam logic [CNT_W-1:0] LD_HOLD_HIGH = CNT_W'(HOLD_CYC_HIGH - 1);
    localparam logic [CNT_W-1:0] LD_SETTLE    = CNT_W'(OSC_SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] LD_LOCK      = CNT_W'(LOCK_CYCLES - 1);
    localparam logic [CNT_W-1:0] LD_RES_FLASH = CNT_W'(RESUME_FLASH_CYC - 1);
    localparam logic [CNT_W-1:0] LD_RES_RAM   = CNT_W'(RESUME_RAM_CYC - 1);

    hmews_phase_t     state_q;
    hmews_gate_t      gate_q;
    logic [1:0]       div_q;
    logic             xtal_q;
    logic             flash_q;
    logic [6:0]       ent_cnt_q;
    logic             wake_s;
    logic             wake_d1_q;
    logic             wake_fall;
    logic             cnt_load;
    logic [CNT_W-1:0] cnt_val;
    logic             cnt_zero;
    logic             sleep_take;
    logic [CNT_W-1:0] hold_ld;

    ////////////////////////////////////////////////////////////////////////
    // Wake pin synchroniser and falling-edge detect on the second stage
    hmews_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (wake_pin),
        .sync_out (wake_s)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_d1_q <= 1'b1;
        end else begin
            wake_d1_q <= wake_s;
        end
    end

    assign wake_fall = wake_d1_q & ~wake_s;

    ////////////////////////////////////////////////////////////////////////
    // Shared phase counter
    hmews_count u_count (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (cnt_load),
        .load_val (cnt_val),
        .zero     (cnt_zero)
    );

    assign sleep_take = (state_q == HMEWS_RUN) && sleep_exec && halt_selected;

    // Hold-off length from the live select at the entry cycle
    always_comb begin
        unique case (clock_divider_select)
            2'b00, 2'b01: hold_ld = LD_HOLD_LOW;
            2'b10:        hold_ld = LD_HOLD_MID;
            2'b11:        hold_ld = LD_HOLD_HIGH;
        endcase
    end

    // Counter load value per phase transition
    always_comb begin
        cnt_load = 1'b0;
        cnt_val  = '0;
        unique case (state_q)
            HMEWS_RUN: begin
                cnt_load = sleep_take;
                cnt_val  = hold_ld;
            end
            HMEWS_HOLD: begin
                cnt_load = 1'b0;
            end
            HMEWS_HALTED: begin
                cnt_load = wake_fall && (ent_cnt_q >= WAKE_GUARD_CYC);
                cnt_val  = xtal_q ? LD_SETTLE : LD_LOCK;
            end
            HMEWS_SETTLE: begin
                cnt_load = cnt_zero;
                cnt_val  = LD_LOCK;
            end
            HMEWS_LOCK: begin
                cnt_load = cnt_zero;
                cnt_val  = flash_q ? LD_RES_FLASH : LD_RES_RAM;
            end
            HMEWS_RESUME: begin
                cnt_load = 1'b0;
            end
            default: begin
                cnt_load = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry settings captured once per sequence
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q   <= 2'h0;
            xtal_q  <= 1'b0;
            flash_q <= 1'b0;
        end else if (sleep_take) begin
            div_q   <= clock_divider_select;
            xtal_q  <= crystal_source;
            flash_q <= wake_from_flash;
        end
    end

    // Cycles since sleep, saturating; idle at zero while running
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ent_cnt_q <= 7'h00;
        end else if (sleep_take) begin
            ent_cnt_q <= 7'h01;
        end else if (state_q == HMEWS_RUN) begin
            ent_cnt_q <= 7'h00;
        end else if (ent_cnt_q != ENT_CNT_MAX) begin
            ent_cnt_q <= ent_cnt_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= HMEWS_RUN;
        end else begin
            unique case (state_q)
                HMEWS_RUN: begin
                    if (sleep_take) begin
                        state_q <= HMEWS_HOLD;
                    end
                end
                HMEWS_HOLD: begin
                    // Fixed count, external memory activity is not waited on
                    if (cnt_zero) begin
                        state_q <= HMEWS_HALTED;
                    end
                end
                HMEWS_HALTED: begin
                    if (cnt_load) begin
                        state_q <= xtal_q ? HMEWS_SETTLE : HMEWS_LOCK;
                    end
                end
                HMEWS_SETTLE: begin
                    if (cnt_zero) begin
                        state_q <= HMEWS_LOCK;
                    end
                end
                HMEWS_LOCK: begin
                    // Full count whether or not the PLL is in use
                    if (cnt_zero) begin
                        state_q <= HMEWS_RESUME;
                    end
                end
                HMEWS_RESUME: begin
                    if (cnt_zero) begin
                        state_q <= HMEWS_RUN;
                    end
                end
                default: begin
                    state_q <= HMEWS_RUN;
                end
            endcase
        end
    end

    // Clock, PLL and oscillator gating
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_q <= GATE_RESET;
        end else begin
            if (state_q == HMEWS_HOLD && cnt_zero) begin
                gate_q.sys_clk_en    <= 1'b0;
                gate_q.core_clk_en   <= 1'b0;
                gate_q.periph_clk_en <= 1'b0;
                gate_q.pll_power_en  <= 1'b0;
                gate_q.osc_en        <= ~xtal_q;
            end
            if (state_q == HMEWS_HALTED && cnt_load) begin
                gate_q.osc_en <= 1'b1;
            end
            if (state_q != HMEWS_RUN && ent_cnt_q == EXTCLK_STOP_CYC) begin
                gate_q.ext_clk_out_en <= 1'b0;
            end
            if (state_q == HMEWS_LOCK && cnt_zero) begin
                gate_q <= GATE_RESET;
            end
        end
    end

    // Resume and interrupt-service pulses at the end of the latency
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            exec_resume <= 1'b0;
            irq_service <= 1'b0;
        end else begin
            exec_resume <= (state_q == HMEWS_RESUME) && cnt_zero;
            irq_service <= (state_q == HMEWS_RESUME) && cnt_zero;
        end
    end

    assign clk_gate = gate_q;
    assign phase    = state_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    localparam int          EXT_LO = 32;
    localparam int          EXT_HI = 45;
    localparam logic [10:0] RES_FL = 11'h465;
    localparam int          RES_RM = 35;

    logic [6:0]       hold_len_q;
    logic [CNT_W-1:0] lock_len_q;
    logic [10:0]      res_len_q;

    // Helper: cycles spent in hold-off and in lock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_len_q <= 7'h00;
            lock_len_q <= '0;
            res_len_q  <= 11'h000;
        end else begin
            res_len_q  <= (state_q == HMEWS_RESUME) ? res_len_q + 11'h001 : 11'h000;
            hold_len_q <= sleep_take ? 7'h01 :
                          (state_q == HMEWS_HOLD) ? hold_len_q + 7'h01 : hold_len_q;
            lock_len_q <= (state_q == HMEWS_LOCK) ? lock_len_q + 1'b1 : '0;
        end
    end

    property p_entry;
        @(posedge core_clk) disable iff (rst)
        (state_q == HMEWS_RUN && sleep_exec && halt_selected) |=> state_q == HMEWS_HOLD;
    endproperty
    a_entry: assert property (p_entry) else $error("Sleep did not start entry");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        $fell(gate_q.sys_clk_en) |->
            $past(hold_len_q) == (div_q == 2'b11 ? 7'd64 : div_q == 2'b10 ? 7'd32 : 7'd16);
    endproperty
    a_hold: assert property (p_hold) else $error("Hold-off length wrong");

    property p_halt_gates;
        @(posedge core_clk) disable iff (rst)
        state_q == HMEWS_HALTED |-> !gate_q.periph_clk_en && !gate_q.pll_power_en;
    endproperty
    a_halt_gates: assert property (p_halt_gates) else $error("Halt gating missing");

    property p_osc_off;
        @(posedge core_clk) disable iff (rst)
        (state_q == HMEWS_HALTED && xtal_q) |-> !gate_q.osc_en;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("Oscillator not stopped");

    property p_wake;
        @(posedge core_clk) disable iff (rst)
        (state_q == HMEWS_HALTED && wake_fall && ent_cnt_q >= WAKE_GUARD_CYC) |=>
            gate_q.osc_en && (state_q == HMEWS_SETTLE || state_q == HMEWS_LOCK);
    endproperty
    a_wake: assert property (p_wake) else $error("Wake edge not honoured");

    property p_lock_len;
        @(posedge core_clk) disable iff (rst)
        $fell(state_q == HMEWS_LOCK) |-> $past(lock_len_q) == CNT_W'(LOCK_CYCLES - 1);
    endproperty
    a_lock_len: assert property (p_lock_len) else $error("Lock interval wrong");

    property p_lock_gated;
        @(posedge core_clk) disable iff (rst)
        state_q == HMEWS_LOCK |-> !gate_q.core_clk_en && !gate_q.sys_clk_en;
    endproperty
    a_lock_gated: assert property (p_lock_gated) else $error("Clock on during lock");

    property p_clk_on;
        @(posedge core_clk) disable iff (rst)
        $rose(state_q == HMEWS_RESUME) |-> gate_q == GATE_RESET;
    endproperty
    a_clk_on: assert property (p_clk_on) else $error("Clocks not restored");

    property p_resume_flash;
        @(posedge core_clk) disable iff (rst)
        (state_q == HMEWS_RESUME && flash_q) |-> res_len_q < RES_FL;
    endproperty
    a_resume_flash: assert property (p_resume_flash) else $error("Flash resume late");

    property p_resume_ram;
        @(posedge core_clk) disable iff (rst)
        ($rose(state_q == HMEWS_RESUME) && !flash_q) |-> ##[1:RES_RM] exec_resume;
    endproperty
    a_resume_ram: assert property (p_resume_ram) else $error("RAM resume late");

    property p_extclk;
        @(posedge core_clk) disable iff (rst)
        sleep_take |-> ##[EXT_LO:EXT_HI] !gate_q.ext_clk_out_en;
    endproperty
    a_extclk: assert property (p_extclk) else $error("External clock stop off");

    // Cycles since sleep come from the saturating entry counter
    property p_extclk_on;
        @(posedge core_clk) disable iff (rst)
        (state_q != HMEWS_RUN && ent_cnt_q <= EXTCLK_STOP_CYC) |-> gate_q.ext_clk_out_en;
    endproperty
    a_extclk_on: assert property (p_extclk_on) else $error("External clock stopped early");

    property p_div_held;
        @(posedge core_clk) disable iff (rst)
        (state_q == HMEWS_HOLD && $past(state_q) == HMEWS_HOLD) |-> $stable(div_q);
    endproperty
    a_div_held: assert property (p_div_held) else $error("Divider changed in hold");

    c_entry: cover property (@(posedge core_clk) disable iff (rst) sleep_take);
    c_halted: cover property (@(posedge core_clk) disable iff (rst)
        $rose(state_q == HMEWS_HALTED));
    c_resume: cover property (@(posedge core_clk) disable iff (rst) exec_resume);

endmodule : hmews_top
`default_nettype wire

// *** tb/hmews_wake_src.sv ***
// Wake source model: pulls the wake pin low for a commanded span.
// Assumes core_clk keeps running; the pin moves on the edge, the design syncs it.
`timescale 1ns/100ps
`default_nettype none
module hmews_wake_src (
    input  wire logic        core_clk,
    input  wire logic        start,
    input  wire logic [11:0] low_len,
    output logic             wake_pin
);
    int n = 0;

    // Pin idles high through its pull-up
    initial wake_pin = 1'b1;

    // Low for low_len core_clk cycles after the start edge, then released high
    always @(posedge core_clk) begin
        if (start && wake_pin) begin
            n = low_len;
            wake_pin <= 1'b0;
        end else if (!wake_pin) begin
            n = n - 1;
            if (n == 0) begin
                wake_pin <= 1'b1;
            end
        end
    end
endmodule : hmews_wake_src
`default_nettype wire

// *** tb/test_hmews_top.sv ***
// Self-checking bench for the halt-mode entry and wake sequencer.
// Assumes a 25 MHz core_clk and a shortened lock interval.
`timescale 1ns/100ps
`default_nettype none
module test_hmews_top;
    import hmews_pkg::*;
    localparam int LOCK = 64;
    logic         core_clk, rst, sleep_exec, halt_selected, start;
    logic         crystal_source, wake_from_flash, wake_pin, exec_resume, irq_service;
    logic [1:0]   clock_divider_select;
    logic [11:0]  low_len;
    hmews_gate_t  clk_gate;
    hmews_phase_t phase;
    int           mismatches = 0;
    int           samples_checked = 0;
    int           seed = 48;
    int           exp_q[$];

    ////////////////////////////////////////////////////////////////////
    // Clock, design and wake source
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    hmews_top #(.LOCK_CYCLES(LOCK)) dut_u (
        .core_clk(core_clk), .rst(rst), .sleep_exec(sleep_exec),
        .halt_selected(halt_selected), .clock_divider_select(clock_divider_select),
        .crystal_source(crystal_source), .wake_from_flash(wake_from_flash),
        .wake_pin(wake_pin), .clk_gate(clk_gate), .phase(phase),
        .exec_resume(exec_resume), .irq_service(irq_service)
    );

    hmews_wake_src wake_u (
        .core_clk(core_clk), .start(start), .low_len(low_len), .wake_pin(wake_pin)
    );

    ////////////////////////////////////////////////////////////////////
    // Compare tasks and helpers
    task automatic chk_int(input string what, input int got);
        int e;
        e = exp_q.pop_front();
        samples_checked++;
        if (got != e) begin
            mismatches++;
            $display("Error %s expected %0d seen %0d", what, e, got);
        end
    endtask : chk_int

    task automatic chk_bits(input string what, input logic [7:0] e, input logic [7:0] got);
        samples_checked++;
        if (got !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask : chk_bits

    // Count cycles while the phase keeps one value, bounded
    task automatic dwell(input hmews_phase_t ph, output int n);
        n = 0;
        while (phase === ph && n < 3000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : dwell

    // Reference hold-off length per divider select
    function automatic int hold_of(input logic [1:0] sel);
        return (sel == 2'b11) ? 64 : (sel == 2'b10) ? 32 : 16;
    endfunction : hold_of

    // Pulse the wake source once
    task automatic kick_wake;
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
    endtask : kick_wake

    ////////////////////////////////////////////////////////////////////
    // One full entry, halt, wake and resume sequence against the model
    task automatic run_seq(input logic [1:0] sel, input logic xtal, input logic fl);
        int n_sys, n_ext, n;
        n_sys = 0;
        n_ext = 0;
        while (wake_pin !== 1'b1) @(posedge core_clk);
        exp_q = {hold_of(sel), 32, 1000, LOCK, fl ? 1125 : 35};
        @(posedge core_clk);
        clock_divider_select <= sel;
        crystal_source <= xtal;
        wake_from_flash <= fl;
        halt_selected <= 1'b1;
        sleep_exec <= 1'b1;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        clock_divider_select <= 2'($random(seed));
        #1;
        chk_bits("phase_entry", {5'h00, HMEWS_HOLD}, {5'h00, phase});
        for (int k = 1; k <= 80; k++) begin
            @(posedge core_clk);
            #1;
            if (clk_gate.sys_clk_en === 1'b0 && n_sys == 0) n_sys = k;
            if (clk_gate.ext_clk_out_en === 1'b0 && n_ext == 0) n_ext = k;
        end
        chk_int("hold_cycles", n_sys);
        chk_int("ext_clk_low", n_ext);
        chk_bits("gates_halt", {2'h0, 4'h0, ~xtal, 1'b0}, {2'h0, clk_gate});
        chk_bits("phase_halt", {5'h00, HMEWS_HALTED}, {5'h00, phase});
        kick_wake();
        dwell(HMEWS_HALTED, n);
        chk_bits("osc_on", 8'h01, {7'h00, clk_gate.osc_en});
        if (xtal) begin
            chk_bits("phase_settle", {5'h00, HMEWS_SETTLE}, {5'h00, phase});
            dwell(HMEWS_SETTLE, n);
            chk_int("settle_cycles", n);
        end else begin
            void'(exp_q.pop_front());
        end
        dwell(HMEWS_LOCK, n);
        chk_int("lock_cycles", n);
        chk_bits("gates_resume", 8'h3f, {2'h0, clk_gate});
        dwell(HMEWS_RESUME, n);
        chk_int("resume_cycles", n);
        chk_bits("resume_pulse", 8'h03, {6'h00, exec_resume, irq_service});
        chk_bits("phase_run", {5'h00, HMEWS_RUN}, {5'h00, phase});
        @(posedge core_clk);
        #1;
        chk_bits("pulse_end", 8'h00, {6'h00, exec_resume, irq_service});
        $display("test seq sel=%0d xtal=%0d flash=%0d done", sel, xtal, fl);
    endtask : run_seq

    ////////////////////////////////////////////////////////////////////
    // Closing task and watchdog
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        results();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        sleep_exec = 1'b0;
        halt_selected = 1'b0;
        start = 1'b0;
        crystal_source = 1'b0;
        wake_from_flash = 1'b0;
        clock_divider_select = 2'h0;
        low_len = 12'(OSC_SETTLE_CYC + 2);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk_bits("gates_reset", 8'h3f, {2'h0, clk_gate});
        chk_bits("phase_reset", {5'h00, HMEWS_RUN}, {5'h00, phase});
        // Sleep without halt selected, and a wake edge while running
        @(posedge core_clk);
        sleep_exec <= 1'b1;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        kick_wake();
        repeat (12) @(posedge core_clk);
        #1;
        chk_bits("phase_refused", {5'h00, HMEWS_RUN}, {5'h00, phase});
        chk_bits("gates_refused", 8'h3f, {2'h0, clk_gate});
        $display("test refused done");
        // Every divider select with and without a crystal source
        for (int i = 0; i < 8; i++) begin
            run_seq(2'(i), i[2], i[0] ^ i[2]);
        end
        results();
    end
endmodule : test_hmews_top
`default_nettype wire
